// [logic/t1tc_pkg.sv]
// Constants shared by the T1 transmit control and loopback block.
// Assumes one 20 MHz clock; one line bit per enabled clock step.
package t1tc_pkg;
   // ----------------------------------------------------------------
   // Register map of the parallel port
   // ----------------------------------------------------------------
   localparam logic [7:0] TCR_TWO_ADDR  = 8'h36;
   localparam logic [7:0] CCR_ONE_ADDR  = 8'h37;
   localparam logic [7:0] REG_RESET     = 8'h00;
   // transmit_control_two fields
   localparam int TEST_HI_POS   = 7;
   localparam int TEST_LO_POS   = 6;
   localparam int ZBTSI_POS     = 5;
   localparam int SYNC_DW_POS   = 4;
   localparam int SYNC_MF_POS   = 3;
   localparam int SYNC_DIR_POS  = 2;
   localparam int YEL_SEL_POS   = 1;
   localparam int B7ZS_POS      = 0;
   // common_control_one fields
   localparam int TX_ES_POS     = 7;
   localparam int OUT_FMT_POS   = 6;
   localparam int ROB_ONES_POS  = 5;
   localparam int TX_SCLK_POS   = 4;
   localparam int RX_SCLK_POS   = 3;
   localparam int RX_ES_POS     = 2;
   localparam int PAY_LOOP_POS  = 1;
   localparam int FRM_LOOP_POS  = 0;
   // Output pin test modes
   localparam logic [1:0] TM_NORMAL = 2'h0;
   localparam logic [1:0] TM_HIZ    = 2'h1;
   localparam logic [1:0] TM_LOW    = 2'h2;
   localparam logic [1:0] TM_HIGH   = 2'h3;
   // ----------------------------------------------------------------
   // Frame structure
   // ----------------------------------------------------------------
   localparam logic [7:0]  FRAME_LAST   = 8'hC0;   // 193 bit slots, 0 is the F bit
   localparam logic [3:0]  MF_LAST      = 4'hB;    // 12 frames per D4 multiframe
   localparam logic [3:0]  SIG_FRAME_A  = 4'h5;
   localparam logic [3:0]  SIG_FRAME_B  = 4'hB;
   localparam logic [3:0]  YEL_FRAME    = 4'hB;    // frame 12
   localparam logic [11:0] D4_FBITS     = 12'h3B1; // Ft/Fs pattern, frame 1 at bit 0
   localparam logic [2:0]  CHAN_START   = 3'h1;
   localparam logic [7:0]  IDLE_BYTE    = 8'h00;
   localparam logic [7:0]  BIT2_MASK    = 8'h40;   // channel bit 2, MSB sent first
   localparam logic [7:0]  BIT7_MASK    = 8'h02;
   // ----------------------------------------------------------------
   // Pulse density
   // ----------------------------------------------------------------
   localparam logic [4:0]  ZERO_RUN_MAX = 5'h0F;
   localparam logic [4:0]  ZERO_RUN_SAT = 5'h10;
   localparam int          DENS_N_MAX   = 23;
   localparam int          HIST_LEN     = 192;
endpackage

// [logic/t1tc_pair_buf.sv]
// Two-entry valid/ready buffer between the backplane byte source and
// the transmit serializer. Assumes a single clock domain.
`timescale 1ns/10ps
module t1tc_pair_buf import t1tc_pkg::*; #(
   parameter int unsigned W = 8
) (
   input  wire logic         clk_i,
   input  wire logic         arst_n_i,
   input  wire logic         s_valid_i,
   input  wire logic [W-1:0] s_data_i,
   output logic              s_ready_o,
   output logic              m_valid_o,
   output logic [W-1:0]      m_data_o,
   input  wire logic         m_ready_i
);
   logic [W-1:0] mem [2];
   logic         wp;
   logic         rp;
   logic [1:0]   fill;
   wire          push = s_valid_i && s_ready_o;
   wire          pop  = m_valid_o && m_ready_i;

   assign s_ready_o = (fill != 2'h2);
   assign m_valid_o = (fill != 2'h0);
   assign m_data_o  = mem[rp];

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wp   <= 1'b0;
         rp   <= 1'b0;
         fill <= 2'h0;
      end else begin
         if (push) wp <= !wp;
         if (pop)  rp <= !rp;
         fill <= fill + {1'b0, push} - {1'b0, pop};
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) mem[wp] <= s_data_i;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   fill_bound_a: assert property (fill <= 2'h2) else $error("buffer overfilled");
endmodule // t1tc_pair_buf

// [logic/t1tc_core.sv]
// T1 transmit control, test modes, loopbacks and pulse density logic.
// Assumes all inputs synchronous to clk_i; one line bit per clock unless held.
// Contract
// - Test mode 00 runs normally; 01 floats every output, I/O and port pin.
// - Test mode 10 drives outputs and I/O low, 11 high; port pins exempt.
// - Transmit zero-byte interchange enable turns that function on or off.
// - Double-wide sync in signaling frames; software clears it in multiframe or input.
// - Sync mode picks per-frame or per-multiframe sync pulses.
// - Sync direction makes the sync pin input (0) or driven output (1).
// - D4 yellow: zeros in channel bit 2, or a one in frame 12 S-bit.
// - Bit-7 suppression forces bit 7 high in all-zero channel bytes.
// - Transmit and receive elastic store enables route or bypass the store.
// - Output format picks bipolar pair, or NRZ on positive with negative low.
// - Robbed-bits-ones forces robbed bits on receive serial output high.
// - System clock rate bits pick 1.544MHz (0) or 2.048MHz (1).
// - Payload loopback returns received payload; framing is regenerated locally.
// - Payload loopback: receive timing, channel outputs low, transmit inputs ignored.
// - Framer loopback: transmit data to receive, unframed ones on the line.
// - Both streams watched for over 15 zeros and sparse ones windows.
// - Transmit and receive density violations reported in separate flags.
// - Density enforcer alters transmitted bits so density rules always hold.
// - Local loop transmits normally unless AIS; transmitted data replaces receive.
`timescale 1ns/10ps
module t1tc_core import t1tc_pkg::*; #(
   parameter int unsigned DW = 8
) (
   input  wire logic          clk_i,
   input  wire logic          arst_n_i,
   input  wire logic          pp_cs_n_i,
   input  wire logic          pp_wr_n_i,
   input  wire logic          pp_rd_n_i,
   input  wire logic [7:0]    pp_addr_i,
   input  wire logic [7:0]    pp_data_i,
   output logic [7:0]         pp_data_o,
   output logic               pp_data_oe_o,
   input  wire logic [DW-1:0] tx_serial_in_i,
   input  wire logic          tx_serial_valid_i,
   output logic               tx_serial_ready_o,
   input  wire logic [DW-1:0] rx_payload_i,
   input  wire logic          tx_yellow_i,
   input  wire logic          tx_line_hold_i,
   input  wire logic          density_enforce_en_i,
   input  wire logic          local_loop_i,
   input  wire logic          line_ais_sel_i,
   input  wire logic          density_flag_clr_i,
   input  wire logic          line_in_pos_i,
   input  wire logic          line_in_neg_i,
   input  wire logic          line_in_valid_i,
   input  wire logic          rx_robbed_slot_i,
   input  wire logic          tx_sync_pin_i,
   output logic               tx_sync_pin_o,
   output logic               tx_sync_pin_oe_o,
   output logic               line_out_pos_o,
   output logic               line_out_neg_o,
   output logic               rx_serial_out_o,
   output logic               tx_channel_clock_o,
   output logic               tx_channel_block_o,
   output logic               pin_drive_en_o,
   output logic               tx_density_viol_o,
   output logic               rx_density_viol_o,
   output logic               tx_zero_byte_interchange_en_o,
   output logic               tx_elastic_en_o,
   output logic               rx_elastic_en_o,
   output logic               tx_sysclk_rate_sel_o,
   output logic               rx_sysclk_rate_sel_o,
   output logic               tx_clock_from_rx_o,
   output logic               rx_clock_from_tx_o,
   output logic               ja_in_loop_o
);
   // ----------------------------------------------------------------
   // Parallel port registers
   // ----------------------------------------------------------------
   logic [7:0] transmit_control_two;
   logic [7:0] common_control_one;
   logic       rd_q;
   logic [7:0] rdata_q;
   wire        wr_en   = !pp_cs_n_i && !pp_wr_n_i;
   wire        rd_en   = !pp_cs_n_i && !pp_rd_n_i;
   wire        hit_tcr = (pp_addr_i == TCR_TWO_ADDR);
   wire        hit_ccr = (pp_addr_i == CCR_ONE_ADDR);
   wire [7:0]  next_rdata = hit_tcr ? transmit_control_two :
                            hit_ccr ? common_control_one : REG_RESET;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         transmit_control_two <= REG_RESET;
         common_control_one   <= REG_RESET;
         rd_q                 <= 1'b0;
         rdata_q              <= REG_RESET;
      end else begin
         if (wr_en && hit_tcr) transmit_control_two <= pp_data_i;
         if (wr_en && hit_ccr) common_control_one <= pp_data_i;
         rd_q    <= rd_en && (hit_tcr || hit_ccr);
         rdata_q <= next_rdata;
      end
   end

   wire [1:0] test_mode = {transmit_control_two[TEST_HI_POS], transmit_control_two[TEST_LO_POS]};
   wire       tm_norm   = (test_mode == TM_NORMAL);
   wire       tm_hiz    = (test_mode == TM_HIZ);
   wire       tm_low    = (test_mode == TM_LOW);
   wire       tm_high   = (test_mode == TM_HIGH);
   wire       sync_dw   = transmit_control_two[SYNC_DW_POS];
   wire       sync_mf   = transmit_control_two[SYNC_MF_POS];
   wire       sync_out  = transmit_control_two[SYNC_DIR_POS];
   wire       yel_sel   = transmit_control_two[YEL_SEL_POS];
   wire       b7zs      = transmit_control_two[B7ZS_POS];
   wire       nrz       = common_control_one[OUT_FMT_POS];
   wire       rob_ones  = common_control_one[ROB_ONES_POS];
   wire       payload_loop_en       = common_control_one[PAY_LOOP_POS];
   wire       framer_loop_en       = common_control_one[FRM_LOOP_POS];

   assign pp_data_o    = rdata_q;
   assign pp_data_oe_o = rd_q && !tm_hiz;

   // Settings steering functions that sit outside this block
   assign tx_zero_byte_interchange_en_o = transmit_control_two[ZBTSI_POS];
   assign tx_elastic_en_o      = common_control_one[TX_ES_POS];
   assign rx_elastic_en_o      = common_control_one[RX_ES_POS];
   assign tx_sysclk_rate_sel_o = common_control_one[TX_SCLK_POS];
   assign rx_sysclk_rate_sel_o = common_control_one[RX_SCLK_POS];
   assign tx_clock_from_rx_o   = payload_loop_en;
   assign rx_clock_from_tx_o   = framer_loop_en;
   assign ja_in_loop_o         = local_loop_i;

   // ----------------------------------------------------------------
   // Transmit framing counters and sync pin
   // ----------------------------------------------------------------
   logic [7:0] bit_pos;
   logic [3:0] frame;
   logic       sync_q;
   wire        adv       = !tx_line_hold_i;
   wire        fbit_slot = (bit_pos == 8'h00);
   wire        load      = adv && (bit_pos[2:0] == CHAN_START);
   // Sync input is only honoured while the pin is an input
   wire        sync_rise = !sync_out && tx_sync_pin_i && !sync_q;
   wire        sig_frame = (frame == SIG_FRAME_A) || (frame == SIG_FRAME_B);
   wire        sync_hit  = !sync_mf || (frame == 4'h0);
   wire        sync_wide = sync_dw && sig_frame && (bit_pos == 8'h01);
   wire        sync_pulse = sync_hit && (fbit_slot || sync_wide);

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         bit_pos <= 8'h00;
         frame   <= 4'h0;
         sync_q  <= 1'b0;
      end else begin
         sync_q <= tx_sync_pin_i;
         if (sync_rise) begin
            bit_pos <= 8'h01;
            if (sync_mf) frame <= 4'h0;
         end else if (adv) begin
            bit_pos <= (bit_pos == FRAME_LAST) ? 8'h00 : bit_pos + 8'h01;
            if (bit_pos == FRAME_LAST) frame <= (frame == MF_LAST) ? 4'h0 : frame + 4'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Transmit byte path
   // ----------------------------------------------------------------
   logic          buf_v;
   logic [DW-1:0] buf_d;
   logic [7:0]    sh;
   // While payload looping, the backplane source is simply not drained
   wire           pop      = load && !payload_loop_en && buf_v;
   wire [7:0]     src_byte = payload_loop_en ? rx_payload_i : (buf_v ? buf_d : IDLE_BYTE);
   wire           yel_d4   = tx_yellow_i && !yel_sel;
   wire [7:0]     yel_byte = yel_d4 ? (src_byte & ~BIT2_MASK) : src_byte;
   wire [7:0]     proc_byte = (b7zs && yel_byte == IDLE_BYTE) ? BIT7_MASK : yel_byte;
   // Framing is always produced here, so looped payload gets fresh F bits
   wire           fbit     = (tx_yellow_i && yel_sel && frame == YEL_FRAME) ||
                             D4_FBITS[frame];
   wire           data_bit = fbit_slot ? fbit : (load ? proc_byte[7] : sh[7]);

   t1tc_pair_buf #(.W(DW)) u_buf (
      .clk_i     (clk_i),
      .arst_n_i  (arst_n_i),
      .s_valid_i (tx_serial_valid_i),
      .s_data_i  (tx_serial_in_i),
      .s_ready_o (tx_serial_ready_o),
      .m_valid_o (buf_v),
      .m_data_o  (buf_d),
      .m_ready_i (pop)
   );

   // ----------------------------------------------------------------
   // Pulse density monitor for both streams, stream 0 is transmit
   // ----------------------------------------------------------------
   logic [HIST_LEN-1:0] hist  [2];
   logic [4:0]          zrun  [2];
   logic [7:0]          cnt   [2][1:DENS_N_MAX];
   logic [DENS_N_MAX:1] risk  [2];
   logic [DENS_N_MAX:1] low   [2];
   logic                step  [2];
   logic                sbit  [2];
   logic                viol  [2];
   logic                flag  [2];

   wire ais_ones  = framer_loop_en || line_ais_sel_i;
   wire enf_force = density_enforce_en_i &&
                    ((|risk[0]) || zrun[0] == ZERO_RUN_MAX);
   wire line_bit  = ais_ones || data_bit || enf_force;

   assign step[0] = adv;
   assign sbit[0] = line_bit;
   assign step[1] = (framer_loop_en || local_loop_i) ? adv : line_in_valid_i;
   assign sbit[1] = framer_loop_en ? data_bit : (local_loop_i ? line_bit : (line_in_pos_i || line_in_neg_i));

   for (genvar s = 0; s < 2; s++) begin : g_stream
      assign viol[s] = step[s] && ((|low[s]) || (zrun[s] == ZERO_RUN_MAX && !sbit[s]));
      always_ff @(posedge clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            hist[s] <= '1;
            zrun[s] <= 5'h00;
            flag[s] <= 1'b0;
         end else begin
            if (step[s]) hist[s] <= {hist[s][HIST_LEN-2:0], sbit[s]};
            if (step[s]) zrun[s] <= sbit[s] ? 5'h00 :
                                    (zrun[s] == ZERO_RUN_SAT) ? zrun[s] : zrun[s] + 5'h01;
            flag[s] <= viol[s] || (flag[s] && !density_flag_clr_i);
         end
      end
      for (genvar n = 1; n <= DENS_N_MAX; n++) begin : g_win
         wire [7:0] drop = cnt[s][n] - {7'h00, hist[s][8*(n+1)-1]};
         assign risk[s][n] = (drop < 8'(n));
         assign low[s][n]  = ((drop + {7'h00, sbit[s]}) < 8'(n));
         always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) cnt[s][n] <= 8'(8*(n+1));
            else if (step[s]) cnt[s][n] <= drop + {7'h00, sbit[s]};
         end
      end
   end

   assign tx_density_viol_o = flag[0];
   assign rx_density_viol_o = flag[1];

   // ----------------------------------------------------------------
   // Line encoder, receive serial output, channel strobes
   // ----------------------------------------------------------------
   logic pos_q;
   logic neg_q;
   logic pol;
   logic rx_ser;
   logic chclk;
   logic chblk;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sh     <= 8'h00;
         pos_q  <= 1'b0;
         neg_q  <= 1'b0;
         pol    <= 1'b0;
         rx_ser <= 1'b0;
         chclk  <= 1'b0;
         chblk  <= 1'b0;
      end else begin
         if (load) sh <= {proc_byte[6:0], 1'b0};
         else if (adv) sh <= {sh[6:0], 1'b0};
         if (adv) begin
            pos_q <= line_bit && (nrz || !pol);
            neg_q <= line_bit && !nrz && pol;
            if (line_bit && !nrz) pol <= !pol;
         end
         if (step[1]) rx_ser <= sbit[1] || (rob_ones && rx_robbed_slot_i);
         chclk <= load && !payload_loop_en;
         chblk <= adv && fbit_slot && !payload_loop_en;
      end
   end

   // Pin test modes sit after every output flop
   assign pin_drive_en_o     = !tm_hiz;
   assign line_out_pos_o     = tm_high || (tm_norm && pos_q);
   // A mark left in the flop by a held serializer must not leak out in NRZ
   assign line_out_neg_o     = tm_high || (tm_norm && neg_q && !nrz);
   assign rx_serial_out_o    = tm_high || (tm_norm && rx_ser);
   assign tx_channel_clock_o = tm_high || (tm_norm && chclk);
   assign tx_channel_block_o = tm_high || (tm_norm && chblk);
   assign tx_sync_pin_o      = tm_high || (tm_norm && sync_pulse);
   assign tx_sync_pin_oe_o   = tm_norm ? sync_out : (tm_low || tm_high);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   hiz_float_a: assert property (tm_hiz |-> !pin_drive_en_o && !pp_data_oe_o
      && !tx_sync_pin_oe_o) else $error("pins driven in float mode");
   force_low_a: assert property (tm_low |-> !line_out_pos_o && !line_out_neg_o
      && tx_sync_pin_oe_o && !tx_sync_pin_o) else $error("pins not low");
   sync_dir_a: assert property (tm_norm |-> tx_sync_pin_oe_o == sync_out)
      else $error("sync pin direction wrong");
   sync_mframe_a: assert property (tm_norm && sync_mf && tx_sync_pin_o |-> frame == 4'h0)
      else $error("multiframe sync off frame");
   b7_stuff_a: assert property (load && b7zs |-> proc_byte != IDLE_BYTE)
      else $error("zero byte left unstuffed");
   nrz_neg_a: assert property (tm_norm && $past(nrz) |-> !line_out_neg_o)
      else $error("negative output active in NRZ");
   plb_chan_a: assert property (payload_loop_en && $past(payload_loop_en) |-> !chclk && !chblk && !pop)
      else $error("channel outputs active in payload loop");
   flb_ones_a: assert property (tm_norm && $past(framer_loop_en) && $past(adv)
      |-> line_out_pos_o || line_out_neg_o) else $error("no mark in framer loop");
   enf_zrun_a: assert property (density_enforce_en_i && adv ##1 density_enforce_en_i
      |-> zrun[0] <= ZERO_RUN_MAX) else $error("zero run too long");
   viol_flag_a: assert property (viol[0] |=> tx_density_viol_o [*2] or
      (tx_density_viol_o ##1 1'b1)) else $error("violation not flagged");
endmodule // t1tc_core

// [testbench/t1tc_src_model.sv]
// Backplane byte source model feeding the transmit buffer.
// Assumes one clock shared with the block; changes only after rising edges.
`timescale 1ns/10ps
module t1tc_src_model (
   input  wire logic       clk_i,
   input  wire logic       arst_n_i,
   input  wire logic       en_i,
   input  wire logic       ready_i,
   output logic            valid_o,
   output logic [7:0]      data_o
);
   logic [7:0] next_byte;
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         valid_o   <= 1'b0;
         data_o    <= 8'h00;
         next_byte <= 8'hE5;
      end else if (valid_o && ready_i) begin
         // Invert released data so a stale byte can never look valid
         valid_o   <= 1'b0;
         data_o    <= ~data_o;
         next_byte <= next_byte + 8'h01;
      end else if (!valid_o && en_i && ($urandom % 2 == 0)) begin
         valid_o <= 1'b1;
         data_o  <= next_byte;
      end else if (!valid_o) begin
         data_o <= ~data_o;
      end
   end
endmodule // t1tc_src_model

// [testbench/tb.sv]
// Self-checking bench for the T1 transmit control block.
// Assumes a 20 MHz clock; reads are checked by a queue-driven monitor.
`timescale 1ns/10ps
module tb import t1tc_pkg::*;;
   logic clk_i = 0, arst_n_i = 0, cs_n = 1, wr_n = 1, rd_n = 1, hold = 0, enf = 0, local_loop = 0;
   logic clr = 0, in_pos = 0, in_neg = 0, in_val = 0, src_en = 0, prev;
   logic yel = 0, ais = 0, rob = 0, watch = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, payload = 8'h00, v, sdata;
   logic oe, sv, srdy, sync_o, sync_oe, pos, neg, rx_serial_out, chclk, chblk, pin_en, txv, rxv;
   logic zb, tes, res, tsc, rsc, tfr, rft, ja;
   logic [7:0] exp_q[$], byte_q[$], des;
   int error_cnt = 0, num_checks = 0, n, des_n = 8;
   always #25 clk_i = ~clk_i;
   t1tc_src_model u_src (.clk_i(clk_i), .arst_n_i(arst_n_i), .en_i(src_en), .ready_i(srdy),
      .valid_o(sv), .data_o(sdata));
   t1tc_core DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .pp_cs_n_i(cs_n), .pp_wr_n_i(wr_n),
      .pp_rd_n_i(rd_n), .pp_addr_i(addr), .pp_data_i(wdata), .pp_data_o(rdata),
      .pp_data_oe_o(oe), .tx_serial_in_i(sdata), .tx_serial_valid_i(sv),
      .tx_serial_ready_o(srdy), .rx_payload_i(payload), .tx_yellow_i(yel),
      .tx_line_hold_i(hold), .density_enforce_en_i(enf), .local_loop_i(local_loop),
      .line_ais_sel_i(ais), .density_flag_clr_i(clr), .line_in_pos_i(in_pos),
      .line_in_neg_i(in_neg), .line_in_valid_i(in_val), .rx_robbed_slot_i(rob),
      .tx_sync_pin_i(1'b0), .tx_sync_pin_o(sync_o), .tx_sync_pin_oe_o(sync_oe),
      .line_out_pos_o(pos), .line_out_neg_o(neg), .rx_serial_out_o(rx_serial_out),
      .tx_channel_clock_o(chclk), .tx_channel_block_o(chblk), .pin_drive_en_o(pin_en),
      .tx_density_viol_o(txv), .rx_density_viol_o(rxv), .tx_zero_byte_interchange_en_o(zb),
      .tx_elastic_en_o(tes), .rx_elastic_en_o(res), .tx_sysclk_rate_sel_o(tsc),
      .rx_sysclk_rate_sel_o(rsc), .tx_clock_from_rx_o(tfr), .rx_clock_from_tx_o(rft),
      .ja_in_loop_o(ja));
   task automatic check(input logic [7:0] seen, input logic [7:0] expd);
      num_checks++;
      if (seen !== expd) begin
         error_cnt++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, expd);
      end
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i); cs_n <= 0; wr_n <= 0; addr <= a; wdata <= d;
      @(posedge clk_i); cs_n <= 1; wr_n <= 1;
   endtask
   // Expected value goes to the queue; unmapped or floated reads must not drive
   task automatic rd(input logic [7:0] a, input logic [7:0] expd, input logic drive);
      if (drive) exp_q.push_back(expd);
      @(posedge clk_i); cs_n <= 0; rd_n <= 0; addr <= a;
      @(posedge clk_i); cs_n <= 1; rd_n <= 1;
      #1 check({7'h0, oe}, {7'h0, drive});
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
   endtask
   // Read data stands from one rising edge to the next, so look mid-cycle
   always @(negedge clk_i) begin
      if (oe === 1'b1) begin
         if (exp_q.size() == 0) check({7'h0, oe}, 8'h00);
         else check(rdata, exp_q.pop_front());
      end
   end
   // Serial bytes restart at each channel clock; idle zero bytes are skipped
   always @(negedge clk_i) begin
      if (watch && sv && srdy) byte_q.push_back(sdata & ~BIT2_MASK);
      if (chclk === 1'b1) des_n = 0;
      if (des_n < 8) begin
         des = {des[6:0], pos};
         des_n++;
         if (des_n == 8 && watch && des != IDLE_BYTE)
            check(des, byte_q.pop_front());
      end
   end
   initial begin
      void'($urandom(85089));
      payload <= $urandom;
      cyc(12); arst_n_i <= 1;
      rd(TCR_TWO_ADDR, REG_RESET, 1); rd(CCR_ONE_ADDR, REG_RESET, 1);
      rd(8'h38, 8'h00, 0);
      #1 check({7'h0, sync_oe}, 8'h00);
      // ----------------------------------------------------------------
      // Random control values, test bits and double-wide left clear
      // ----------------------------------------------------------------
      for (int i = 0; i < 6; i++) begin
         v = $urandom & 8'h2F;
         wr(TCR_TWO_ADDR, v); rd(TCR_TWO_ADDR, v, 1); #1;
         check({6'h0, zb, sync_oe}, {6'h0, v[ZBTSI_POS], v[SYNC_DIR_POS]});
         // One bench clock: the recovered clock is never looped to transmit
         v = $urandom & 8'hFC; @(posedge clk_i); local_loop <= v[2];
         wr(CCR_ONE_ADDR, v); wr(8'h39, 8'hFF); rd(CCR_ONE_ADDR, v, 1); #1;
         check({tes, res, tsc, rsc, ja}, {v[7], v[2], v[4], v[3], v[2]});
      end
      // ----------------------------------------------------------------
      // Output pin test modes
      // ----------------------------------------------------------------
      wr(CCR_ONE_ADDR, 8'h00); local_loop <= 0; wr(TCR_TWO_ADDR, 8'h80); cyc(2); #1;
      check({pos, neg, rx_serial_out, pin_en, sync_o, sync_oe, chclk, chblk}, 8'h14);
      wr(TCR_TWO_ADDR, 8'hC0); cyc(2); #1;
      check({pos, neg, rx_serial_out, pin_en, sync_o, sync_oe, chclk, chblk}, 8'hFF);
      wr(TCR_TWO_ADDR, 8'h40); cyc(2); #1;
      check({6'h0, pin_en, sync_oe}, 8'h00);
      rd(TCR_TWO_ADDR, 8'h40, 0);
      wr(TCR_TWO_ADDR, 8'h00); cyc(2); #1 check({7'h0, pin_en}, 8'h01);
      // ----------------------------------------------------------------
      // Framer loop: unframed ones, AMI then NRZ
      // ----------------------------------------------------------------
      // Receive timing comes from the one bench clock, never a tied copy
      wr(CCR_ONE_ADDR, 8'h01); cyc(4); #1 check({7'h0, rft}, 8'h01);
      prev = pos;
      for (int i = 0; i < 40; i++) begin
         @(posedge clk_i); #1 check({pos ^ neg, pos}, {1'b1, ~prev});
         prev = pos;
      end
      wr(CCR_ONE_ADDR, 8'h41); cyc(4);
      repeat (20) begin @(posedge clk_i); #1 check({pos, neg}, 2'h2); end
      // ----------------------------------------------------------------
      // Robbed bits forced high, line AIS
      // ----------------------------------------------------------------
      wr(CCR_ONE_ADDR, 8'h60); rob <= 1; ais <= 1; in_val <= 1; cyc(3); #1;
      check({rx_serial_out, pos, neg}, 3'h6);
      @(posedge clk_i); rob <= 0; ais <= 0; cyc(3); #1;
      check({7'h0, rx_serial_out}, 8'h00);
      // ----------------------------------------------------------------
      // Payload loop silences channel timing outputs
      // ----------------------------------------------------------------
      wr(CCR_ONE_ADDR, 8'h00); n = 0;
      repeat (400) begin @(posedge clk_i); #1 n += chclk + chblk; end
      check({7'h0, n > 0}, 8'h01);
      wr(CCR_ONE_ADDR, 8'h02); cyc(2); n = 0;
      repeat (400) begin @(posedge clk_i); #1 n += chclk + chblk; end
      check({6'h0, n > 0, tfr}, 8'h01);
      // ----------------------------------------------------------------
      // Buffer fills under stall, then drains onto the NRZ line
      // ----------------------------------------------------------------
      wr(CCR_ONE_ADDR, 8'h40); hold <= 1; src_en <= 1; yel <= 1; watch <= 1; cyc(20); #1;
      check({7'h0, srdy}, 8'h00);
      @(posedge clk_i); src_en <= 0; hold <= 0; n = 0;
      while (byte_q.size() != 0 && n < 500) begin @(posedge clk_i); n++; end
      if (n == 500) error_cnt++;
      check({7'h0, srdy}, 8'h01);
      watch <= 0;
      yel <= 0;
      // ----------------------------------------------------------------
      // Density monitor and enforcer
      // ----------------------------------------------------------------
      // No line coding runs in this bench, so the enforcer may be on
      in_val <= 1; in_pos <= 1; enf <= 1; clr <= 1; cyc(40); clr <= 0;
      in_pos <= 0; cyc(15); in_pos <= 1; cyc(3); #1;
      check({txv, rxv}, 2'h0);
      @(posedge clk_i); in_pos <= 0; cyc(16); in_pos <= 1; cyc(3); #1;
      check({txv, rxv}, 2'h1);
      cyc(600); #1 check({7'h0, txv}, 8'h00);
      @(posedge clk_i); enf <= 0; cyc(600); #1 check({7'h0, txv}, 8'h01);
      cyc(4); close_out();
   end
endmodule // tb
